/* src/irq_ctrl_pkg.sv */
// constants, offsets and field layouts of the interrupt control block
package irq_ctrl_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int EXT_N  = 5;
  localparam int IRQ_W  = 4;

  typedef logic [REG_W-1:0] word_t;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL1      = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL2      = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FLAGS0     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FLAGS1     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 8'h14;

  // control register 1 fields
  localparam int BIT_NESTING_DISABLE = 15;
  localparam int BIT_ARITH_TRAP      = 4;
  localparam int BIT_ADDRESS_TRAP    = 3;
  localparam int BIT_STACK_TRAP      = 2;
  localparam int BIT_OSC_FAIL_TRAP   = 1;
  localparam word_t TRAP_MASK        = 16'h001E;

  // control register 2 fields
  localparam int BIT_ALT_VECTOR  = 15;
  localparam int BIT_HOLD_ACTIVE = 14;
  localparam int LSB_EXT_FALLING = 0;

  // implemented flag positions
  localparam word_t FLAGS0_MASK = 16'h3FEF;
  localparam word_t FLAGS1_MASK = 16'hFEDF;
  localparam int BIT_EXT0_FLAG  = 0;
  localparam int BIT_EXT1_FLAG  = 4;
  localparam int BIT_EXT2_FLAG  = 13;

  // interrupt status bits
  localparam int IRQ_BIT_FLAGS0 = 0;
  localparam int IRQ_BIT_FLAGS1 = 1;
  localparam int IRQ_BIT_TRAP   = 2;
  localparam int IRQ_BIT_EXT    = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_ALL = 4'hF;

  // reset values
  localparam word_t RESET_WORD             = 16'h0000;
  localparam logic [EXT_N-1:0] RESET_EXT   = 5'h00;
  localparam logic [IRQ_W-1:0] RESET_IRQ   = 4'h0;
  localparam logic [DATA_W-1:0] RESET_DATA = 32'h0000_0000;

  // bus answer phase
  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

endpackage

/* src/sticky_flag_bank.sv */
// sticky flag bank: hardware sets, software writes, set wins
`timescale 1ns/10ps
module sticky_flag_bank #(
  parameter int               WIDTH = 16,
  parameter logic [WIDTH-1:0] MASK  = '1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] setReq,
  input  wire logic             wrEn,
  input  wire logic [WIDTH-1:0] wrData,
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] held;
  logic [WIDTH-1:0] next_flags;

  // software value first, then hardware set on top
  assign held       = wrEn ? wrData : flags;
  assign next_flags = (held | setReq) & MASK;

  // flag storage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

endmodule // sticky_flag_bank

/* src/ext_edge_detect.sv */
// external pin synchroniser and selectable edge detector
`timescale 1ns/10ps
module ext_edge_detect (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pinIn,
  input  wire logic fallingSelect,
  output logic      edgePulse
);

  logic syncFirst;
  logic syncSecond;
  logic lastLevel;
  logic next_edgePulse;

  // transitions compare only synchronised levels
  assign next_edgePulse = fallingSelect ? (lastLevel & ~syncSecond)
                                        : (~lastLevel & syncSecond);

  // two-stage synchroniser, history and pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncFirst  <= 1'b0;
      syncSecond <= 1'b0;
      lastLevel  <= 1'b0;
      edgePulse  <= 1'b0;
    end else begin
      syncFirst  <= pinIn;
      syncSecond <= syncFirst;
      lastLevel  <= syncSecond;
      edgePulse  <= next_edgePulse;
    end
  end

endmodule // ext_edge_detect

/* src/irq_control_and_flag_regs.sv */
// interrupt global control, trap status and flag banks behind APB
//
// What this block does
// - control 1 bit 15 set disables nesting; clear allows preemption.
// - control 1 bit 4 latches arithmetic overflow trap, else reads 0.
// - control 1 bit 3 latches address error trap, else reads 0.
// - control 1 bit 2 latches stack error trap, else reads 0.
// - control 1 bit 1 latches oscillator failure trap, else reads 0.
// - control 2 bit 15 selects alternate vector table when set.
// - control 2 bit 14 reads 1 while interrupt hold countdown runs.
// - control 2 bits 4..0 pick falling (1) or rising (0) edges.
// - flags set by their source; software reads and writes them.
// - bank 0 carries converter, serial, timer, compare, capture, ext0.
// - bank 1 carries serial 2, ext2, timers, compares, captures, more.
// - unimplemented bits read 0 and ignore writes.
// - every implemented bit is 0 after power-on reset.
// - a set flag stays set until software clears it.
// - nesting disabled makes the cpu priority level read-only.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module irq_control_and_flag_regs
  import irq_ctrl_pkg::*;
#(
  parameter int EXT_PINS = EXT_N
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // event sources
  input  wire logic [REG_W-1:0]  bank0Req,
  input  wire logic [REG_W-1:0]  bank1Req,
  input  wire logic              arithTrapReq,
  input  wire logic              addressTrapReq,
  input  wire logic              stackTrapReq,
  input  wire logic              oscFailTrapReq,
  input  wire logic              irqHoldActiveIn,
  input  wire logic [EXT_PINS-1:0] extPin,
  // results
  output logic [REG_W-1:0]       flags0,
  output logic [REG_W-1:0]       flags1,
  output logic                   nesting_disable,
  output logic                   cpuPriorityReadOnly,
  output logic                   alt_vector_select,
  output logic [EXT_PINS-1:0]    extEdge,
  output logic                   irq
);

  // control and status storage
  word_t                trapFlags;
  logic                 irq_hold_active;
  logic [EXT_PINS-1:0]  extFallingSelect;
  logic [IRQ_W-1:0]     irqStatus;
  logic [IRQ_W-1:0]     irqMask;
  bus_state_t           busState;
  bus_state_t           next_busState;

  // named polarity bits
  logic ext0_falling_select;
  logic ext1_falling_select;
  logic ext2_falling_select;
  logic ext3_falling_select;
  logic ext4_falling_select;

  // bus phases and decode
  logic       setupPhase;
  logic       accessDone;
  logic       writeDone;
  logic       readDone;
  logic       aligned;
  logic       hitCtrl1;
  logic       hitCtrl2;
  logic       hitFlags0;
  logic       hitFlags1;
  logic       hitStatus;
  logic       hitMask;
  logic       mapped;
  logic       wrCtrl1;
  logic       wrCtrl2;
  logic       wrFlags0;
  logic       wrFlags1;
  logic       wrMask;
  logic       rdStatus;
  word_t      wrWord;

  // assembled read words
  word_t              ctrl1Word;
  word_t              ctrl2Word;
  logic [DATA_W-1:0]  readMux;

  // hardware set requests
  word_t              trapSet;
  word_t              set0;
  word_t              set1;
  logic [IRQ_W-1:0]   irqEvents;
  logic [IRQ_W-1:0]   statusKeep;
  logic               next_irq;
  logic               next_pready;

  // trap bit names
  logic arith_trap_flag;
  logic address_trap_flag;
  logic stack_trap_flag;
  logic osc_fail_trap_flag;

  // polarity fields by pin
  assign ext0_falling_select = extFallingSelect[0];
  assign ext1_falling_select = extFallingSelect[1];
  assign ext2_falling_select = extFallingSelect[2];
  assign ext3_falling_select = extFallingSelect[3];
  assign ext4_falling_select = extFallingSelect[4];

  // trap field views
  assign arith_trap_flag    = trapFlags[BIT_ARITH_TRAP];
  assign address_trap_flag  = trapFlags[BIT_ADDRESS_TRAP];
  assign stack_trap_flag    = trapFlags[BIT_STACK_TRAP];
  assign osc_fail_trap_flag = trapFlags[BIT_OSC_FAIL_TRAP];

  // apb phase qualifiers
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign writeDone  = accessDone & pwrite;
  assign readDone   = accessDone & ~pwrite;

  // address decode, word aligned only
  // an unaligned address misses every register and answers an error
  assign aligned   = (paddr[1:0] == 2'b00);
  assign hitCtrl1  = aligned & (paddr == OFF_CTRL1);
  assign hitCtrl2  = aligned & (paddr == OFF_CTRL2);
  assign hitFlags0 = aligned & (paddr == OFF_FLAGS0);
  assign hitFlags1 = aligned & (paddr == OFF_FLAGS1);
  assign hitStatus = aligned & (paddr == OFF_IRQ_STATUS);
  assign hitMask   = aligned & (paddr == OFF_IRQ_MASK);
  assign mapped    = hitCtrl1 | hitCtrl2 | hitFlags0 | hitFlags1
                   | hitStatus | hitMask;

  // write strobes at the completing edge
  assign wrWord   = pwdata[REG_W-1:0];
  assign wrCtrl1  = writeDone & hitCtrl1;
  assign wrCtrl2  = writeDone & hitCtrl2;
  assign wrFlags0 = writeDone & hitFlags0;
  assign wrFlags1 = writeDone & hitFlags1;
  assign wrMask   = writeDone & hitMask;
  assign rdStatus = readDone & hitStatus;

  // control words, unimplemented bits tied low
  assign ctrl1Word = {nesting_disable, 10'h000, trapFlags[4:1], 1'b0};
  assign ctrl2Word = {alt_vector_select, irq_hold_active, 9'h000,
                      extFallingSelect};

  // read data selection
  assign readMux = hitCtrl1  ? {16'h0000, ctrl1Word} :
                   hitCtrl2  ? {16'h0000, ctrl2Word} :
                   hitFlags0 ? {16'h0000, flags0} :
                   hitFlags1 ? {16'h0000, flags1} :
                   hitStatus ? {28'h000_0000, irqStatus} :
                   hitMask   ? {28'h000_0000, irqMask} :
                   RESET_DATA;

  // trap sources into their latched positions
  assign trapSet = {11'h000, arithTrapReq, addressTrapReq,
                    stackTrapReq, oscFailTrapReq, 1'b0};

  // bank 0 sources, ext0 taken from its edge detector
  always_comb begin
    set0                = bank0Req & FLAGS0_MASK;
    set0[BIT_EXT0_FLAG] = extEdge[0];
  end

  // bank 1 sources, ext1 and ext2 taken from edge detectors
  always_comb begin
    set1                = bank1Req & FLAGS1_MASK;
    set1[BIT_EXT1_FLAG] = extEdge[1];
    set1[BIT_EXT2_FLAG] = extEdge[2];
  end

  // events that raise the block interrupt
  assign irqEvents[IRQ_BIT_FLAGS0] = |set0;
  assign irqEvents[IRQ_BIT_FLAGS1] = |set1;
  assign irqEvents[IRQ_BIT_TRAP]   = |trapSet;
  assign irqEvents[IRQ_BIT_EXT]    = |extEdge;

  // a status read clears only what the captured read data showed
  // an event landing in the same cycle as that read is kept, set wins
  assign statusKeep = irqStatus & ~prdata[IRQ_W-1:0];
  assign next_irq   = |(irqStatus & irqMask);

  // one answer cycle after every setup cycle
  assign next_busState = setupPhase ? BUS_ANSWER : BUS_IDLE;

  // external pin edge detectors
  // one detector per pin; ext3 and ext4 pulses leave for another bank
  genvar gi;
  generate
    for (gi = 0; gi < EXT_PINS; gi++) begin : gExt
      ext_edge_detect uEdge (
        .clk           (clk),
        .resetn        (resetn),
        .pinIn         (extPin[gi]),
        .fallingSelect (extFallingSelect[gi]),
        .edgePulse     (extEdge[gi])
      );
    end
  endgenerate

  // trap status bits of control register 1
  // trap bits stay writable so software can clear them once serviced
  sticky_flag_bank #(
    .WIDTH (REG_W),
    .MASK  (TRAP_MASK)
  ) uTrap (
    .clk    (clk),
    .resetn (resetn),
    .setReq (trapSet),
    .wrEn   (wrCtrl1),
    .wrData (wrWord),
    .flags  (trapFlags)
  );

  // flag bank 0
  sticky_flag_bank #(
    .WIDTH (REG_W),
    .MASK  (FLAGS0_MASK)
  ) uBank0 (
    .clk    (clk),
    .resetn (resetn),
    .setReq (set0),
    .wrEn   (wrFlags0),
    .wrData (wrWord),
    .flags  (flags0)
  );

  // flag bank 1
  sticky_flag_bank #(
    .WIDTH (REG_W),
    .MASK  (FLAGS1_MASK)
  ) uBank1 (
    .clk    (clk),
    .resetn (resetn),
    .setReq (set1),
    .wrEn   (wrFlags1),
    .wrData (wrWord),
    .flags  (flags1)
  );

  // block interrupt status, cleared by reading it
  sticky_flag_bank #(
    .WIDTH (IRQ_W),
    .MASK  (IRQ_MASK_ALL)
  ) uStatus (
    .clk    (clk),
    .resetn (resetn),
    .setReq (irqEvents),
    .wrEn   (rdStatus),
    .wrData (statusKeep),
    .flags  (irqStatus)
  );

  // nesting control and priority lock
  // the cpu must honour the lock; the level bits live outside this block
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nesting_disable     <= 1'b0;
      cpuPriorityReadOnly <= 1'b0;
    end else if (wrCtrl1) begin
      nesting_disable     <= pwdata[BIT_NESTING_DISABLE];
      cpuPriorityReadOnly <= pwdata[BIT_NESTING_DISABLE];
    end
  end

  // vector table select and edge polarities
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alt_vector_select <= 1'b0;
      extFallingSelect  <= RESET_EXT;
    end else if (wrCtrl2) begin
      alt_vector_select <= pwdata[BIT_ALT_VECTOR];
      extFallingSelect  <= pwdata[LSB_EXT_FALLING +: EXT_PINS];
    end
  end

  // hold status mirrors the cpu, writes ignored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_hold_active <= 1'b0;
    end else begin
      irq_hold_active <= irqHoldActiveIn;
    end
  end

  // interrupt mask and output
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqMask <= RESET_IRQ;
      irq     <= 1'b0;
    end else begin
      if (wrMask) begin
        irqMask <= pwdata[IRQ_W-1:0];
      end
      irq <= next_irq;
    end
  end

  // pready decoded from the state being entered
  always_comb begin
    case (next_busState)
      BUS_IDLE:   next_pready = 1'b0;
      BUS_ANSWER: next_pready = 1'b1;
      default:    next_pready = 1'b0;
    endcase
  end

  // apb answer phase state; pready kept in a flop of its own so the
  // output carries no decode logic between register and pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busState <= BUS_IDLE;
      pready   <= 1'b0;
    end else begin
      busState <= next_busState;
      pready   <= next_pready;
    end
  end

  // read data and error captured in the setup cycle
  // capturing early lets the access cycle answer with no wait state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= RESET_DATA;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata  <= pwrite ? RESET_DATA : readMux;
      pslverr <= ~mapped;
    end
  end

endmodule // irq_control_and_flag_regs

/* tb/irq_ctrl_monitor.sv */
// port-level checks for the interrupt control block
`timescale 1ns/10ps
module irq_ctrl_monitor
  import irq_ctrl_pkg::*;
#(
  parameter int EXT_PINS = EXT_N
) (
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [DATA_W-1:0]   pwdata,
  input wire logic                pready,
  input wire logic [REG_W-1:0]    bank0Req,
  input wire logic [REG_W-1:0]    bank1Req,
  input wire logic [REG_W-1:0]    flags0,
  input wire logic [REG_W-1:0]    flags1,
  input wire logic                nesting_disable,
  input wire logic                cpuPriorityReadOnly,
  input wire logic                alt_vector_select,
  input wire logic [EXT_PINS-1:0] extEdge,
  input wire logic                irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // write access edge decode per register
  wire logic acc    = psel && penable && pready && pwrite;
  wire logic wrC1   = acc && (paddr == OFF_CTRL1);
  wire logic wrC2   = acc && (paddr == OFF_CTRL2);
  wire logic wrF0   = acc && (paddr == OFF_FLAGS0);
  wire logic wrF1   = acc && (paddr == OFF_FLAGS1);
  wire word_t req0  = bank0Req & 16'h3FEE;
  wire word_t req1  = bank1Req & 16'hDECF;
  property p_nest;
    wrC1 |=> nesting_disable == $past(pwdata[15]);
  endproperty
  property p_ro;
    wrC1 |=> cpuPriorityReadOnly == $past(pwdata[15]);
  endproperty
  property p_alt;
    wrC2 |=> alt_vector_select == $past(pwdata[15]);
  endproperty
  property p_set0;
    req0 != '0 |=> (flags0 & $past(req0)) == $past(req0);
  endproperty
  property p_set1;
    req1 != '0 |=> (flags1 & $past(req1)) == $past(req1);
  endproperty
  property p_unimp;
    (flags0 & ~FLAGS0_MASK) == '0 && (flags1 & ~FLAGS1_MASK) == '0;
  endproperty
  property p_keep0;
    !wrF0 |=> (flags0 & $past(flags0)) == $past(flags0);
  endproperty
  property p_keep1;
    !wrF1 |=> (flags1 & $past(flags1)) == $past(flags1);
  endproperty
  property p_ext0;
    extEdge[0] |=> flags0[BIT_EXT0_FLAG];
  endproperty
  property p_ext2;
    extEdge[2] |=> flags1[BIT_EXT2_FLAG];
  endproperty
  a_nest: assert property (p_nest) else $error("nesting bit");
  a_ro: assert property (p_ro) else $error("level lock");
  a_alt: assert property (p_alt) else $error("vector select");
  a_set0: assert property (p_set0) else $error("bank0 set");
  a_set1: assert property (p_set1) else $error("bank1 set");
  a_unimp: assert property (p_unimp) else $error("unused bit");
  a_keep0: assert property (p_keep0) else $error("bank0 lost");
  a_keep1: assert property (p_keep1) else $error("bank1 lost");
  a_ext0: assert property (p_ext0) else $error("ext0 flag");
  a_ext2: assert property (p_ext2) else $error("ext2 flag");
  // main scenarios reached
  c_nest: cover property (wrC1 && pwdata[15]);
  c_ext: cover property (extEdge[0]);
  c_irq: cover property ($rose(irq));
endmodule // irq_ctrl_monitor

/* tb/irq_source_model.sv */
// peripheral and pin sources feeding the block's request inputs
`timescale 1ns/10ps
module irq_source_model
  import irq_ctrl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire word_t            set0,
  input  wire word_t            set1,
  input  wire logic [3:0]       trapSet,
  input  wire logic [EXT_N-1:0] pinLvl,
  output word_t                 bank0Req,
  output word_t                 bank1Req,
  output logic [3:0]            trapReq,
  output logic [EXT_N-1:0]      extPin
);
  // sources present requests in step with the system clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bank0Req <= RESET_WORD;
      bank1Req <= RESET_WORD;
      trapReq  <= 4'h0;
      extPin   <= RESET_EXT;
    end else begin
      bank0Req <= set0;
      bank1Req <= set1;
      trapReq  <= trapSet;
      extPin   <= pinLvl;
    end
  end
endmodule // irq_source_model

/* tb/irq_control_and_flag_regs_tb.sv */
// register-level testbench for the interrupt control block
`timescale 1ns/10ps
module irq_control_and_flag_regs_tb
  import irq_ctrl_pkg::*;
;
  logic              clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, q;
  word_t             bank0Req, bank1Req, flags0, flags1, s0, s1;
  logic [3:0]        trapReq, ts;
  logic [EXT_N-1:0]  extPin, extEdge, pinLvl, seenEdge;
  logic              irqHoldActiveIn, nesting_disable, irq;
  logic              cpuPriorityReadOnly, alt_vector_select;
  int                error_cnt = 0, total_checks = 0, cycles = 0, i;
  irq_control_and_flag_regs dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bank0Req(bank0Req), .bank1Req(bank1Req),
    .arithTrapReq(trapReq[3]), .addressTrapReq(trapReq[2]),
    .stackTrapReq(trapReq[1]), .oscFailTrapReq(trapReq[0]),
    .irqHoldActiveIn(irqHoldActiveIn), .extPin(extPin), .flags0(flags0),
    .flags1(flags1), .nesting_disable(nesting_disable),
    .cpuPriorityReadOnly(cpuPriorityReadOnly),
    .alt_vector_select(alt_vector_select), .extEdge(extEdge), .irq(irq));
  irq_source_model src (.clk(clk), .resetn(resetn), .set0(s0),
    .set1(s1), .trapSet(ts), .pinLvl(pinLvl), .bank0Req(bank0Req),
    .bank1Req(bank1Req), .trapReq(trapReq), .extPin(extPin));
  // clock of 50 ns period
  always #25 clk = ~clk;
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, then access held until pready
  task xfer(input logic w, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    xfer(1'b0, a, '0);
    chk(q, e);
  endtask
  // one-cycle request from the sources, then settle
  task pulse(input word_t a, input word_t b, input logic [3:0] t);
    @(posedge clk);
    s0 <= a; s1 <= b; ts <= t;
    @(posedge clk);
    s0 <= '0; s1 <= '0; ts <= '0;
    repeat (3) @(posedge clk);
  endtask
  // pulses seen on every edge output since reset
  always @(posedge clk) seenEdge <= resetn ? (seenEdge | extEdge) : '0;
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    clk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
    pwdata = '0; irqHoldActiveIn = 0; s0 = '0; s1 = '0; ts = '0;
    pinLvl = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 4; i++) rd(8'(4 * i), '0);
    rd(8'h18, '0);
    chk(32'(pslverr), 32'h0000_0001);
    wr(OFF_CTRL1, 32'h0000_FFFF);
    rd(OFF_CTRL1, 32'h0000_801E);
    chk(32'(cpuPriorityReadOnly), 32'h0000_0001);
    wr(OFF_CTRL1, '0);
    @(posedge clk);
    chk(32'(cpuPriorityReadOnly), '0);
    // each trap source latches its own bit
    for (i = 0; i < 4; i++) begin
      pulse('0, '0, 4'(1 << i));
      rd(OFF_CTRL1, 32'(2 << i));
      wr(OFF_CTRL1, '0);
    end
    wr(OFF_CTRL2, 32'h0000_FFFF);
    rd(OFF_CTRL2, 32'h0000_801F);
    chk(32'(alt_vector_select), 32'h0000_0001);
    irqHoldActiveIn <= 1'b1;
    rd(OFF_CTRL2, 32'h0000_C01F);
    irqHoldActiveIn <= 1'b0;
    rd(OFF_CTRL2, 32'h0000_801F);
    wr(OFF_CTRL2, 32'h0000_0002);
    pulse(16'hFFFF, 16'hFFFF, '0);
    repeat (4) @(posedge clk);
    rd(OFF_FLAGS0, 32'h0000_3FEE);
    rd(OFF_FLAGS1, 32'h0000_DECF);
    wr(OFF_FLAGS0, 32'h0000_FFFF);
    rd(OFF_FLAGS0, 32'h0000_3FEF);
    wr(OFF_FLAGS1, 32'h0000_FFFF);
    rd(OFF_FLAGS1, 32'h0000_FEDF);
    wr(OFF_FLAGS0, '0);
    wr(OFF_FLAGS1, '0);
    rd(OFF_FLAGS0, '0);
    // rising edges on all pins, ext1 waits for its falling edge
    pinLvl <= 5'h1F;
    repeat (8) @(posedge clk);
    rd(OFF_FLAGS0, 32'h0000_0001);
    rd(OFF_FLAGS1, 32'h0000_2000);
    chk(32'(seenEdge), 32'h0000_001D);
    pinLvl <= 5'h1D;
    repeat (8) @(posedge clk);
    rd(OFF_FLAGS1, 32'h0000_2010);
    chk(32'(seenEdge), 32'h0000_001F);
    // trap event raises irq only while unmasked
    wr(OFF_IRQ_MASK, '0);
    pulse('0, '0, 4'h1);
    chk(32'(irq), '0);
    wr(OFF_IRQ_MASK, 32'h0000_0004);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0000_0001);
    wr(OFF_IRQ_MASK, '0);
    wr(OFF_CTRL1, '0);
    repeat (3) @(posedge clk);
    chk(32'(irq), '0);
    xfer(1'b0, OFF_IRQ_STATUS, '0);
    chk(q & 32'h0000_0004, 32'h0000_0004);
    xfer(1'b0, OFF_IRQ_STATUS, '0);
    chk(q & 32'h0000_0004, '0);
    give_verdict();
  end
endmodule // irq_control_and_flag_regs_tb
bind irq_control_and_flag_regs irq_ctrl_monitor #(.EXT_PINS(EXT_PINS))
  u_mon (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .bank0Req(bank0Req), .bank1Req(bank1Req), .flags0(flags0),
    .flags1(flags1), .nesting_disable(nesting_disable),
    .cpuPriorityReadOnly(cpuPriorityReadOnly),
    .alt_vector_select(alt_vector_select), .extEdge(extEdge), .irq(irq));
